// file: verilog/pxc_pkg.sv
package pxc_pkg;

	// ----------------------------------------------------------------
	// Register addresses on the management bus
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_NP     = 5'h08;
	localparam logic [4:0] ADDR_RSV_LO = 5'h09;
	localparam logic [4:0] ADDR_RSV_HI = 5'h0F;
	localparam logic [4:0] ADDR_EXT    = 5'h10;
	localparam logic [4:0] ADDR_QP     = 5'h11;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int NP_CODE_HI  = 3;
	localparam int NP_CODE_LO  = 0;
	localparam int EXT_OVR     = 15;
	localparam int EXT_PA_HI   = 10;
	localparam int EXT_PA_LO   = 6;
	localparam int EXT_CTEST   = 5;
	localparam int EXT_NRZI    = 3;
	localparam int EXT_TXINV   = 2;
	localparam int EXT_CDIS    = 0;
	localparam int QP_SPEED    = 15;
	localparam int QP_DUPLEX   = 14;
	localparam int QP_AN_HI    = 13;
	localparam int QP_AN_LO    = 12;
	localparam int AN_CODE_HI  = 2;
	localparam int AN_CODE_LO  = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic        NRZI_RST  = 1'b1;
	localparam logic        CDIS_RST  = 1'b0;
	localparam logic        TXINV_RST = 1'b0;
	localparam logic        CTEST_RST = 1'b0;
	localparam logic        OVR_RST   = 1'b0;
	localparam logic [3:0]  NP_RST    = 4'h0;
	localparam logic [1:0]  AN_RST    = 2'h0;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	// ----------------------------------------------------------------
	// Management frame layout
	// ----------------------------------------------------------------
	localparam logic [5:0] PRE_LEN   = 6'h20;
	localparam logic [4:0] HDR_LAST  = 5'h0D;
	localparam logic [4:0] TA_LAST   = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0F;
	localparam logic [1:0] ST_CODE   = 2'h1;
	localparam logic [1:0] OP_WR     = 2'h1;
	localparam logic [1:0] OP_RD     = 2'h2;

	typedef enum logic [3:0] {
		S_PRE  = 4'h1,
		S_HDR  = 4'h2,
		S_TA   = 4'h4,
		S_DATA = 4'h8
	} pxc_state_t;

endpackage

// file: verilog/pxc_mdio_frame.sv
module pxc_mdio_frame (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        mdc,
	input  wire logic        mdio_i,
	input  wire logic [4:0]  phy_addr,
	input  wire logic [15:0] rd_word,
	output logic             mdio_o,
	output logic             mdio_oe_n,
	output logic [4:0]       reg_addr,
	output logic [15:0]      wr_data,
	output logic             wr_stb,
	output logic             rd_stb
);

	logic                mdc_q;
	pxc_pkg::pxc_state_t state_q;
	logic [4:0]          cnt_q;
	logic [5:0]          ones_q;
	logic [15:0]         sh_q;
	logic                is_rd_q;

	wire        mdc_rise = clk_en & mdc & ~mdc_q;
	wire [13:0] hdr      = {sh_q[12:0], mdio_i};
	wire        op_rd    = hdr[11:10] == pxc_pkg::OP_RD;
	wire        op_wr    = hdr[11:10] == pxc_pkg::OP_WR;
	wire        hdr_ok   = (hdr[13:12] == pxc_pkg::ST_CODE) & (op_rd | op_wr)
	                       & (hdr[9:5] == phy_addr);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			mdc_q <= 1'b0;
		else if (clk_en)
			mdc_q <= mdc;
	end

	// ----------------------------------------------------------------
	// Frame engine, stepped on each MDC rising edge
	// ----------------------------------------------------------------
	// Read data changes just after the rising edge so the controller
	// sees it settled for a whole MDC period.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= pxc_pkg::S_PRE;
			cnt_q     <= 5'h00;
			ones_q    <= 6'h00;
			sh_q      <= 16'h0000;
			is_rd_q   <= 1'b0;
			mdio_o    <= 1'b0;
			mdio_oe_n <= 1'b1;
			reg_addr  <= 5'h00;
			wr_data   <= 16'h0000;
			wr_stb    <= 1'b0;
			rd_stb    <= 1'b0;
		end else if (clk_en) begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (mdc_rise) begin
				unique case (state_q)
					pxc_pkg::S_PRE: begin
						if (mdio_i) begin
							ones_q <= (ones_q == pxc_pkg::PRE_LEN) ? ones_q : ones_q + 6'h01;
						end else begin
							if (ones_q == pxc_pkg::PRE_LEN) begin
								state_q <= pxc_pkg::S_HDR;
								cnt_q   <= 5'h01;
								sh_q    <= 16'h0000;
							end
							ones_q <= 6'h00;
						end
					end
					pxc_pkg::S_HDR: begin
						sh_q  <= {sh_q[14:0], mdio_i};
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == pxc_pkg::HDR_LAST) begin
							cnt_q    <= 5'h00;
							reg_addr <= hdr[4:0];
							is_rd_q  <= op_rd;
							rd_stb   <= hdr_ok & op_rd;
							// Frames for another station are dropped here
							state_q  <= hdr_ok ? pxc_pkg::S_TA : pxc_pkg::S_PRE;
						end
					end
					pxc_pkg::S_TA: begin
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q != pxc_pkg::TA_LAST) begin
							mdio_o    <= 1'b0;
							mdio_oe_n <= ~is_rd_q;
						end else begin
							cnt_q   <= 5'h00;
							state_q <= pxc_pkg::S_DATA;
							mdio_o  <= is_rd_q & rd_word[15];
							sh_q    <= {rd_word[14:0], 1'b0};
						end
					end
					pxc_pkg::S_DATA: begin
						cnt_q  <= cnt_q + 5'h01;
						mdio_o <= is_rd_q & sh_q[15];
						sh_q   <= is_rd_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], mdio_i};
						if (cnt_q == pxc_pkg::DATA_LAST) begin
							state_q   <= pxc_pkg::S_PRE;
							mdio_o    <= 1'b0;
							mdio_oe_n <= 1'b1;
							wr_stb    <= ~is_rd_q;
							wr_data   <= {sh_q[14:0], mdio_i};
						end
					end
					default: state_q <= pxc_pkg::S_PRE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_pin_released_idle;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_q == pxc_pkg::S_PRE) |-> mdio_oe_n;
	endproperty
	a_pin_released_idle: assert property (p_pin_released_idle)
		else $error("management pin driven outside a read frame");

endmodule

// file: verilog/pxc_ext_regs.sv
// Notes on behaviour
// - Partner next-page code bits 3:0 read-only, reset zero, loaded from received page.
// - Addresses 9 to 15 are reserved: read zero, writes ignored.
// - Writable NRZI select (default 1), cipher disable and invalid-code transmit (default 0).
// - Quick-poll bit 15 shows speed 100, bit 14 full duplex, read-only.
// - Progress code bits 2:1 read-only, reset zero, held between reads.
module pxc_ext_regs (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	input  wire logic       mdc,
	input  wire logic       mdio_i,
	output logic            mdio_o,
	output logic            mdio_oe_n,
	input  wire logic [4:0] phy_addr_strap,
	input  wire logic       np_page_rx,
	input  wire logic [3:0] np_code_rx,
	input  wire logic       link_speed_100,
	input  wire logic       link_full_duplex,
	input  wire logic [2:0] an_progress_code,
	input  wire logic       ovr_done,
	output logic            ovr_en,
	output logic            nrzi_en,
	output logic            cipher_dis,
	output logic            tx_invalid_en,
	output logic            cipher_test_en
);

	function automatic logic is_reserved(input logic [4:0] a);
		is_reserved = (a >= pxc_pkg::ADDR_RSV_LO) && (a <= pxc_pkg::ADDR_RSV_HI);
	endfunction

	// ----------------------------------------------------------------
	// Reset release and strap capture
	// ----------------------------------------------------------------
	logic       rst_meta_q;
	logic       rst_n;
	logic       strap_done_q;
	logic [4:0] phy_addr_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Strap pins are taken once, after reset has gone away
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'b0;
			phy_addr_q   <= 5'h00;
		end else if (clk_en && !strap_done_q) begin
			strap_done_q <= 1'b1;
			phy_addr_q   <= phy_addr_strap;
		end
	end

	// ----------------------------------------------------------------
	// Serial management frame engine
	// ----------------------------------------------------------------
	logic [4:0]  reg_addr;
	logic [15:0] wr_data;
	logic        wr_stb;
	logic        rd_stb;
	logic [15:0] rd_word_q;

	pxc_mdio_frame u_frame (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.mdc       (mdc),
		.mdio_i    (mdio_i),
		.phy_addr  (phy_addr_q),
		.rd_word   (rd_word_q),
		.mdio_o    (mdio_o),
		.mdio_oe_n (mdio_oe_n),
		.reg_addr  (reg_addr),
		.wr_data   (wr_data),
		.wr_stb    (wr_stb),
		.rd_stb    (rd_stb)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [3:0] np_code_q;
	logic [1:0] anpm_q;

	wire hit_np  = reg_addr == pxc_pkg::ADDR_NP;
	wire hit_ext = reg_addr == pxc_pkg::ADDR_EXT;
	wire hit_qp  = reg_addr == pxc_pkg::ADDR_QP;
	wire hit_rsv = is_reserved(reg_addr);
	wire wr_ext  = wr_stb & hit_ext;
	wire rd_qp   = rd_stb & hit_qp;
	wire ovr_set = wr_ext & wr_data[pxc_pkg::EXT_OVR];

	logic [15:0] np_word;
	logic [15:0] ext_word;
	logic [15:0] qp_word;
	logic [15:0] rd_mux;

	always_comb begin
		np_word = pxc_pkg::WORD_ZERO;
		np_word[pxc_pkg::NP_CODE_HI:pxc_pkg::NP_CODE_LO] = np_code_q;
		ext_word = pxc_pkg::WORD_ZERO;
		ext_word[pxc_pkg::EXT_OVR] = ovr_en;
		ext_word[pxc_pkg::EXT_PA_HI:pxc_pkg::EXT_PA_LO] = phy_addr_q;
		ext_word[pxc_pkg::EXT_CTEST] = cipher_test_en;
		ext_word[pxc_pkg::EXT_NRZI] = nrzi_en;
		ext_word[pxc_pkg::EXT_TXINV] = tx_invalid_en;
		ext_word[pxc_pkg::EXT_CDIS] = cipher_dis;
		qp_word = pxc_pkg::WORD_ZERO;
		qp_word[pxc_pkg::QP_SPEED] = link_speed_100;
		qp_word[pxc_pkg::QP_DUPLEX] = link_full_duplex;
		qp_word[pxc_pkg::QP_AN_HI:pxc_pkg::QP_AN_LO] = anpm_q;
	end

	// Reserved and unmapped addresses fall through to zero
	assign rd_mux = hit_np  ? np_word  :
	                hit_ext ? ext_word :
	                hit_qp  ? qp_word  : pxc_pkg::WORD_ZERO;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rd_word_q <= pxc_pkg::WORD_ZERO;
		else if (clk_en && rd_stb)
			rd_word_q <= rd_mux;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			np_code_q <= pxc_pkg::NP_RST;
		else if (clk_en && np_page_rx)
			np_code_q <= np_code_rx;
	end

	// Snapshot is refreshed after each read, so a read shows the code as
	// it stood at the previous read; changes between two reads are not kept.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			anpm_q <= pxc_pkg::AN_RST;
		else if (clk_en && rd_qp)
			anpm_q <= an_progress_code[pxc_pkg::AN_CODE_HI:pxc_pkg::AN_CODE_LO];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nrzi_en        <= pxc_pkg::NRZI_RST;
			cipher_dis     <= pxc_pkg::CDIS_RST;
			tx_invalid_en  <= pxc_pkg::TXINV_RST;
			cipher_test_en <= pxc_pkg::CTEST_RST;
		end else if (clk_en && wr_ext) begin
			nrzi_en        <= wr_data[pxc_pkg::EXT_NRZI];
			cipher_dis     <= wr_data[pxc_pkg::EXT_CDIS];
			tx_invalid_en  <= wr_data[pxc_pkg::EXT_TXINV];
			cipher_test_en <= wr_data[pxc_pkg::EXT_CTEST];
		end
	end

	// A new write of one wins over the core's acknowledge in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ovr_en <= pxc_pkg::OVR_RST;
		else if (clk_en)
			ovr_en <= ovr_set | (ovr_en & ~ovr_done);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [15:0] ext_shadow;
	assign ext_shadow = {cipher_test_en, nrzi_en, tx_invalid_en, cipher_dis, 12'h000};

	property p_np_load;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && np_page_rx) |=> (np_code_q == $past(np_code_rx));
	endproperty
	a_np_load: assert property (p_np_load)
		else $error("next-page code not loaded from received page");

	property p_np_held;
		@(posedge sys_clk) disable iff (!rst_n)
		!(clk_en && np_page_rx) |=> $stable(np_code_q);
	endproperty
	a_np_held: assert property (p_np_held)
		else $error("next-page code changed without a received page");

	property p_rsv_read_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && rd_stb && is_reserved(reg_addr)) |=> (rd_word_q == pxc_pkg::WORD_ZERO);
	endproperty
	a_rsv_read_zero: assert property (p_rsv_read_zero)
		else $error("reserved address read back non-zero");

	property p_rsv_write_ignored;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && wr_stb && hit_rsv) |=> ($stable(ext_shadow) && !$rose(ovr_en));
	endproperty
	a_rsv_write_ignored: assert property (p_rsv_write_ignored)
		else $error("write to reserved address changed a control bit");

	property p_ext_write;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && wr_ext) |=> (nrzi_en == $past(wr_data[pxc_pkg::EXT_NRZI])
		                        && cipher_dis == $past(wr_data[pxc_pkg::EXT_CDIS])
		                        && tx_invalid_en == $past(wr_data[pxc_pkg::EXT_TXINV]));
	endproperty
	a_ext_write: assert property (p_ext_write)
		else $error("extended control write not applied");

	property p_qp_speed_duplex;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && rd_qp) |=> (rd_word_q[pxc_pkg::QP_SPEED] == $past(link_speed_100)
		                      && rd_word_q[pxc_pkg::QP_DUPLEX] == $past(link_full_duplex));
	endproperty
	a_qp_speed_duplex: assert property (p_qp_speed_duplex)
		else $error("quick-poll speed or duplex wrong");

	property p_anpm_held;
		@(posedge sys_clk) disable iff (!rst_n)
		!(clk_en && rd_qp) |=> $stable(anpm_q);
	endproperty
	a_anpm_held: assert property (p_anpm_held)
		else $error("progress code changed between reads");

	property p_ovr_clear;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && ovr_en && ovr_done && !ovr_set) |=> !ovr_en;
	endproperty
	a_ovr_clear: assert property (p_ovr_clear)
		else $error("override enable did not clear after acknowledge");

	property p_ovr_set;
		@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && ovr_set) |=> ovr_en;
	endproperty
	a_ovr_set: assert property (p_ovr_set)
		else $error("override enable not set by write");

	c_ext_write: cover property (@(posedge sys_clk) disable iff (!rst_n) clk_en && wr_ext);
	c_qp_read: cover property (@(posedge sys_clk) disable iff (!rst_n) clk_en && rd_qp);
	c_ovr_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && ovr_set) ##[1:1000] (clk_en && ovr_done));

endmodule

// file: dv/pxc_sta_model.sv
module pxc_sta_model (
	input  wire logic sys_clk,
	input  wire logic mdio_o,
	input  wire logic mdio_oe_n,
	output logic      mdc,
	output logic      mdio_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// Half of one mdc period in sys_clk cycles; the bench raises it for slow frames
	int   half = 3;
	logic drv_q;
	logic drv_oe;

	// Device wins while it drives; a released line floats to the pull-up
	assign mdio_i = !mdio_oe_n ? mdio_o : (drv_oe ? drv_q : 1'b1);

	initial begin
		mdc = 1'b0;
		drv_q = 1'b1;
		drv_oe = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Data set up while mdc is low, line sampled just before the rise
	task automatic cyc(input logic oe, input logic b, output logic s);
		drv_oe = oe;
		drv_q = b;
		wait_clk(half);
		s = mdio_i;
		mdc = 1'b1;
		wait_clk(half);
		mdc = 1'b0;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rd, output logic ta);
		logic [13:0] hdr;
		logic        s;
		logic        wr;
		hdr = {2'h1, op, pa, ra};
		wr = (op == 2'h1);
		for (int i = 0; i < 32; i++) cyc(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) cyc(1'b1, hdr[i], s);
		cyc(wr, 1'b1, s);
		cyc(wr, 1'b0, s);
		ta = s;
		for (int i = 15; i >= 0; i--) begin
			cyc(wr, wd[i], s);
			rd[i] = s;
		end
		drv_oe = 1'b0;
		wait_clk(4);
	endtask
endmodule

// file: dv/pxc_ext_regs_tb.sv
module pxc_ext_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        sys_clk, rstn, mdc, mdio_i, mdio_o, mdio_oe_n, np_page_rx, ovr_done;
	logic        link_speed_100, link_full_duplex, ovr_en, nrzi_en, cipher_dis;
	logic        tx_invalid_en, cipher_test_en, ta, clk_en;
	logic [4:0]  strap;
	logic [3:0]  np_code;
	logic [2:0]  an_code;
	logic [15:0] rd;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          seed = 33888;

	pxc_ext_regs dut_u (
		.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .mdc(mdc), .mdio_i(mdio_i),
		.mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .phy_addr_strap(strap),
		.np_page_rx(np_page_rx), .np_code_rx(np_code), .link_speed_100(link_speed_100),
		.link_full_duplex(link_full_duplex), .an_progress_code(an_code),
		.ovr_done(ovr_done), .ovr_en(ovr_en), .nrzi_en(nrzi_en), .cipher_dis(cipher_dis),
		.tx_invalid_en(tx_invalid_en), .cipher_test_en(cipher_test_en)
	);

	pxc_sta_model sta_u (
		.sys_clk(sys_clk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
		.mdio_i(mdio_i)
	);

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] f_ext(input logic [15:0] w, input logic ovr);
		return {ovr, 4'h0, strap, w[5], 1'b0, w[3], w[2], 1'b0, w[0]};
	endfunction

	function automatic logic [15:0] f_qp(input logic [2:0] snap);
		return {link_speed_100, link_full_duplex, snap[2:1], 12'h000};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask

	// Order: override, cipher test, nrzi, invalid codes, cipher disable
	task automatic chk_ports(input logic [4:0] exp);
		total_checks++;
		if ({ovr_en, cipher_test_en, nrzi_en, tx_invalid_en, cipher_dis} !== exp) begin
			n_mismatch++;
			$display("BAD %0t control outputs differ from %b", $time, exp);
		end
	endtask

	task automatic rd_reg(input logic [4:0] ra);
		sta_u.frame(pxc_pkg::OP_RD, strap, ra, 16'h0000, rd, ta);
	endtask

	task automatic wr_reg(input logic [4:0] ra, input logic [15:0] w);
		sta_u.frame(pxc_pkg::OP_WR, strap, ra, w, rd, ta);
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#600000;
		n_mismatch++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] w;
		logic        ovr;
		logic [2:0]  snap;
		rstn = 1'b0;
		clk_en = 1'b1;
		np_page_rx = 1'b0;
		ovr_done = 1'b0;
		np_code = 4'h0;
		strap = 5'($random(seed));
		link_speed_100 = 1'($random(seed));
		link_full_duplex = 1'($random(seed));
		an_code = 3'($random(seed));
		ovr = 1'b0;
		snap = 3'h0;
		w = 16'h0008;
		step(3);
		rstn = 1'b1;
		step(6);
		chk_ports(5'b00100);
		rd_reg(pxc_pkg::ADDR_EXT);
		chk_word(rd, f_ext(w, 1'b0));
		rd_reg(pxc_pkg::ADDR_NP);
		chk_word(rd, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			if (i >= 3) sta_u.half = 5;
			np_code = 4'($random(seed));
			np_page_rx = 1'b1;
			step(1);
			np_page_rx = 1'b0;
			wr_reg(pxc_pkg::ADDR_NP, 16'($random(seed)));
			rd_reg(pxc_pkg::ADDR_NP);
			chk_word(rd, {12'h000, np_code});
			wr_reg(pxc_pkg::ADDR_QP, 16'($random(seed)));
			rd_reg(pxc_pkg::ADDR_QP);
			chk_word(rd, f_qp(snap));
			snap = an_code;
			link_speed_100 = 1'($random(seed));
			link_full_duplex = 1'($random(seed));
			an_code = 3'($random(seed));
			w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
			wr_reg(pxc_pkg::ADDR_EXT, w);
			ovr = ovr | w[15];
			chk_ports({ovr, w[5], w[3], w[2], w[0]});
			rd_reg(pxc_pkg::ADDR_EXT);
			chk_word(rd, f_ext(w, ovr));
			if (ovr) begin
				ovr_done = 1'b1;
				step(1);
				ovr_done = 1'b0;
				step(2);
				ovr = 1'b0;
				chk_ports({ovr, w[5], w[3], w[2], w[0]});
			end
		end
		for (int a = 9; a <= 15; a++) begin
			wr_reg(5'(a), 16'hFFFF);
			rd_reg(5'(a));
			chk_word(rd, 16'h0000);
		end
		chk_ports({ovr, w[5], w[3], w[2], w[0]});
		// Enable low freezes both the next-page capture and the override clear
		wr_reg(pxc_pkg::ADDR_EXT, w | 16'h8000);
		clk_en = 1'b0;
		np_page_rx = 1'b1;
		ovr_done = 1'b1;
		np_code = ~np_code;
		step(2);
		np_page_rx = 1'b0;
		chk_ports({1'b1, w[5], w[3], w[2], w[0]});
		clk_en = 1'b1;
		step(2);
		ovr_done = 1'b0;
		chk_ports({1'b0, w[5], w[3], w[2], w[0]});
		rd_reg(pxc_pkg::ADDR_NP);
		chk_word(rd, {12'h000, ~np_code});
		// A frame for another station must leave the line to the pull-up
		sta_u.frame(pxc_pkg::OP_RD, strap ^ 5'h01, pxc_pkg::ADDR_EXT, 16'h0000, rd, ta);
		chk_word({rd[14:0], ta}, 16'hFFFF);
		sta_u.frame(pxc_pkg::OP_WR, strap ^ 5'h01, pxc_pkg::ADDR_EXT, ~w, rd, ta);
		rd_reg(pxc_pkg::ADDR_EXT);
		chk_word(rd, f_ext(w, ovr));
		// Reset in mid-run restores the control bits, the page code and the snapshot
		rstn = 1'b0;
		step(1);
		chk_ports(5'b00100);
		rstn = 1'b1;
		step(6);
		rd_reg(pxc_pkg::ADDR_NP);
		chk_word(rd, 16'h0000);
		rd_reg(pxc_pkg::ADDR_QP);
		chk_word(rd, f_qp(3'h0));
		summarize();
	end
endmodule
